/* seo_params.svh */
`ifndef SEO_PARAMS_SVH
`define SEO_PARAMS_SVH

// Register byte offsets
`define SEO_ADDR_CFG      8'h00
`define SEO_ADDR_CFG_ACT  8'h04
`define SEO_ADDR_DECEL    8'h08
`define SEO_ADDR_CMD      8'h0C
`define SEO_ADDR_STATUS   8'h10
`define SEO_ADDR_IRQ_STAT 8'h14
`define SEO_ADDR_IRQ_MASK 8'h18

// Configuration field width and reset value
`define SEO_CFG_W         10
`define SEO_CFG_RST       10'h000

// Deceleration rate limits and reset value
`define SEO_DECEL_W       27
`define SEO_DECEL_MIN     27'h0000001
`define SEO_DECEL_MAX     27'h5F5E0FF
`define SEO_DECEL_RST     27'h00003E8

// Command register bits
`define SEO_CMD_SERIAL_SERVO_ENABLE_COMMAND_BIT  0
`define SEO_CMD_RESTART_BIT 1

// Selector codes
`define SEO_SEL_ALWAYS    2'h2
`define SEO_SEL_NEVER     2'h3

// Interrupt event bits
`define SEO_IRQ_W         4
`define SEO_IRQ_FWD_OT    0
`define SEO_IRQ_REV_OT    1
`define SEO_IRQ_OT_OFF    2
`define SEO_IRQ_STOPPED   3

// AXI responses
`define SEO_RESP_OKAY     2'h0
`define SEO_RESP_SLVERR   2'h2

`endif

/* seo_pkg.sv */
package seo_pkg;

    typedef enum logic [1:0] {ST_OFF, ST_RUN, ST_DECEL, ST_LOCK} seo_state_t;

    typedef enum logic [2:0] {
        STOP_NONE, STOP_SVOFF, STOP_IMMED, STOP_DECEL_RAMP, STOP_HOLD
    } seo_stop_t;

    typedef struct packed {
        logic [1:0] servo_off_stop_method;
        logic [1:0] overtravel_stop_method;
        logic [1:0] reverse_limit_select;
        logic [1:0] forward_limit_select;
        logic [1:0] servo_enable_input_select;
    } seo_cfg_t;

    typedef struct packed {
        logic fwd_req;
        logic rev_req;
        logic at_target;
        logic sw_limit;
        logic stopped;
    } seo_motion_t;

    typedef struct packed {
        logic power;
        logic allow_fwd;
        logic allow_rev;
        logic pos_done;
        logic fwd_ot;
        logic rev_ot;
    } seo_drive_t;

endpackage

/* seo_servo_enable.sv */
`timescale 1ns/1ns
`default_nettype none
`include "seo_params.svh"

module seo_servo_enable
    import seo_pkg::*;
(
    input  wire logic                    core_clk_i,
    input  wire logic                    nrst_i,
    input  wire logic                    servo_enable_i,
    input  wire logic                    forward_limit_input_i,
    input  wire logic                    reverse_limit_input_i,
    input  wire seo_motion_t             motion_i,
    output var  seo_drive_t              drive_o,
    output var  seo_stop_t               stop_mode_o,
    output var  logic [1:0]              servo_off_stop_method_o,
    output var  logic [`SEO_DECEL_W-1:0] overtravel_decel_rate_o,
    output var  logic                    irq_o,
    input  wire logic [7:0]              s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output var  logic                    s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output var  logic                    s_axi_wready,
    output var  logic [1:0]              s_axi_bresp,
    output var  logic                    s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [7:0]              s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output var  logic                    s_axi_arready,
    output var  logic [31:0]             s_axi_rdata,
    output var  logic [1:0]              s_axi_rresp,
    output var  logic                    s_axi_rvalid,
    input  wire logic                    s_axi_rready
);

    // Enable polarity decode
    function automatic logic en_decode(input logic [1:0] sel, input logic closed);
        case (sel)
            2'h0:    en_decode = closed;
            2'h1:    en_decode = !closed;
            2'h2:    en_decode = 1'b1;
            default: en_decode = 1'b0;
        endcase
    endfunction
    // Limit polarity decode, high means prohibited
    function automatic logic lim_decode(input logic [1:0] sel, input logic closed);
        case (sel)
            2'h0:    lim_decode = !closed;
            2'h1:    lim_decode = closed;
            2'h2:    lim_decode = 1'b1;
            default: lim_decode = 1'b0;
        endcase
    endfunction
    // Byte lane mask from write strobes
    function automatic logic [31:0] lane_mask(input logic [3:0] strb);
        lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction

    logic [2:0]              sync1_reg;
    logic [2:0]              sync2_reg;
    seo_cfg_t                cfg_reg;
    seo_cfg_t                cfg_act_reg;
    logic                    restart_reg;
    logic [`SEO_DECEL_W-1:0] decel_reg;
    logic [`SEO_IRQ_W-1:0]   irq_stat_reg;
    logic [`SEO_IRQ_W-1:0]   irq_mask_reg;
    seo_state_t              state_reg;
    seo_state_t              state_next;
    logic                    lockout_reg;
    logic                    en_prev_reg;
    logic                    fwd_ot_reg;
    logic                    rev_ot_reg;
    logic [7:0]              aw_addr_reg;
    logic [31:0]             w_data_reg;
    logic [3:0]              w_strb_reg;

    // Two-stage synchronisers for enable and limit contacts
    always_ff @(posedge core_clk_i)
    begin
        sync1_reg <= {reverse_limit_input_i, forward_limit_input_i, servo_enable_i};
        sync2_reg <= sync1_reg;
    end
    // Decoded input levels
    wire logic en_lvl = en_decode(cfg_act_reg.servo_enable_input_select, sync2_reg[0]);
    wire logic fwd_ot = lim_decode(cfg_act_reg.forward_limit_select, sync2_reg[1]);
    wire logic rev_ot = lim_decode(cfg_act_reg.reverse_limit_select, sync2_reg[2]);
    wire logic ot_now = fwd_ot | rev_ot;
    wire logic fwd_onset = fwd_ot & !fwd_ot_reg;
    wire logic rev_onset = rev_ot & !rev_ot_reg;
    wire logic ot_onset = fwd_onset | rev_onset;
    wire logic en_rise = en_lvl & !en_prev_reg;
    wire logic power_ok = en_lvl & !lockout_reg;
    // Register bus decode
    wire logic wr_fire = !s_axi_awready & !s_axi_wready & !s_axi_bvalid;
    wire logic [31:0] wmask = lane_mask(w_strb_reg);
    wire logic [31:0] wbits = w_data_reg & wmask;
    wire logic wr_cfg = wr_fire & (aw_addr_reg == `SEO_ADDR_CFG);
    wire logic wr_decel = wr_fire & (aw_addr_reg == `SEO_ADDR_DECEL);
    wire logic wr_cmd = wr_fire & (aw_addr_reg == `SEO_ADDR_CMD);
    wire logic wr_stat = wr_fire & (aw_addr_reg == `SEO_ADDR_IRQ_STAT);
    wire logic wr_mask = wr_fire & (aw_addr_reg == `SEO_ADDR_IRQ_MASK);
    wire logic wr_ro = (aw_addr_reg == `SEO_ADDR_CFG_ACT) | (aw_addr_reg == `SEO_ADDR_STATUS);
    wire logic wr_hit = wr_cfg | wr_decel | wr_cmd | wr_stat | wr_mask | (wr_fire & wr_ro);
    wire logic serial_servo_enable_command_cmd = wr_cmd & wbits[`SEO_CMD_SERIAL_SERVO_ENABLE_COMMAND_BIT];
    wire logic soft_restart = wr_cmd & wbits[`SEO_CMD_RESTART_BIT];
    wire logic restart_now = restart_reg;
    wire logic [31:0] cfg_merged = ({22'h0, cfg_reg} & ~wmask) | wbits;
    wire logic [31:0] decel_merged = ({5'h0, decel_reg} & ~wmask) | wbits;
    wire logic [31:0] mask_merged = ({28'h0, irq_mask_reg} & ~wmask) | wbits;
    wire logic decel_ok = (decel_merged[31:`SEO_DECEL_W] == 5'h0)
                        & (decel_merged[`SEO_DECEL_W-1:0] >= `SEO_DECEL_MIN)
                        & (decel_merged[`SEO_DECEL_W-1:0] <= `SEO_DECEL_MAX);
    // Serial servo-on has no effect while enable is forced always on
    wire logic serial_servo_enable_command_accept = serial_servo_enable_command_cmd
        & (cfg_act_reg.servo_enable_input_select != `SEO_SEL_ALWAYS);
    wire logic lock_clear = en_rise | serial_servo_enable_command_accept | restart_now;
    wire logic method_svoff = (cfg_act_reg.overtravel_stop_method == 2'h0)
                            | (cfg_act_reg.overtravel_stop_method == 2'h3);
    wire logic lock_set = (state_reg == ST_RUN) & power_ok & ot_onset & method_svoff;
    wire logic lockout_next = lock_set | (lockout_reg & !lock_clear);
    // Stop sequencing
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_OFF:
                if (power_ok)
                    state_next = ST_RUN;
            ST_RUN:
                if (!power_ok)
                    state_next = ST_OFF;
                else if (ot_onset && method_svoff)
                    state_next = ST_OFF;
                else if (ot_onset && cfg_act_reg.overtravel_stop_method == 2'h1)
                    state_next = ST_LOCK;
                else if (ot_onset)
                    state_next = ST_DECEL;
            ST_DECEL:
                if (!power_ok)
                    state_next = ST_OFF;
                else if (motion_i.stopped)
                    state_next = ST_LOCK;
            ST_LOCK:
                if (!power_ok)
                    state_next = ST_OFF;
                else if (!ot_now)
                    state_next = ST_RUN;
            default: state_next = ST_OFF;
        endcase
        if (restart_now)
            state_next = ST_OFF;
    end

    wire logic power_next = (state_next != ST_OFF);
    wire logic moving_ok = power_next & (state_next != ST_DECEL);
    wire seo_stop_t stop_next = (state_next == ST_OFF)   ? STOP_SVOFF :
                                (state_next == ST_DECEL) ? STOP_DECEL_RAMP :
                                (state_next == ST_LOCK && state_reg == ST_RUN) ? STOP_IMMED :
                                (state_next == ST_LOCK)  ? STOP_HOLD : STOP_NONE;
    // Interrupt events
    wire logic [`SEO_IRQ_W-1:0] irq_ev = {
        (state_next == ST_LOCK) & (state_reg != ST_LOCK),
        lock_set, rev_onset, fwd_onset};
    wire logic [`SEO_IRQ_W-1:0] irq_clr = wr_stat ? wbits[`SEO_IRQ_W-1:0] : 4'h0;
    wire logic [`SEO_IRQ_W-1:0] irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_ev;
    // Read decode
    wire logic [7:0] ra = s_axi_araddr;
    wire logic rd_hit = (ra == `SEO_ADDR_CFG) | (ra == `SEO_ADDR_CFG_ACT)
                      | (ra == `SEO_ADDR_DECEL) | (ra == `SEO_ADDR_CMD)
                      | (ra == `SEO_ADDR_STATUS) | (ra == `SEO_ADDR_IRQ_STAT)
                      | (ra == `SEO_ADDR_IRQ_MASK);
    logic [31:0] rd_val;
    always_comb
    begin
        if (ra == `SEO_ADDR_CFG)
            rd_val = {22'h0, cfg_reg};
        else if (ra == `SEO_ADDR_CFG_ACT)
            rd_val = {22'h0, cfg_act_reg};
        else if (ra == `SEO_ADDR_DECEL)
            rd_val = {5'h0, decel_reg};
        else if (ra == `SEO_ADDR_STATUS)
            rd_val = {26'h0, state_reg, lockout_reg, rev_ot_reg, fwd_ot_reg, drive_o.power};
        else if (ra == `SEO_ADDR_IRQ_STAT)
            rd_val = {28'h0, irq_stat_reg};
        else if (ra == `SEO_ADDR_IRQ_MASK)
            rd_val = {28'h0, irq_mask_reg};
        else
            rd_val = 32'h0;
    end
    // Configuration, latched into the active copy on restart
    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            cfg_reg     <= `SEO_CFG_RST;
            cfg_act_reg <= `SEO_CFG_RST;
            restart_reg <= 1'b1;
            decel_reg   <= `SEO_DECEL_RST;
            irq_mask_reg <= 4'h0;
        end
        else
        begin
            if (wr_cfg)
                cfg_reg <= cfg_merged[`SEO_CFG_W-1:0];
            if (restart_reg)
                cfg_act_reg <= cfg_reg;
            restart_reg <= soft_restart;
            if (wr_decel && decel_ok)
                decel_reg <= decel_merged[`SEO_DECEL_W-1:0];
            if (wr_mask)
                irq_mask_reg <= mask_merged[`SEO_IRQ_W-1:0];
        end
    end

    // Core state
    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            state_reg    <= ST_OFF;
            lockout_reg  <= 1'b0;
            en_prev_reg  <= 1'b0;
            fwd_ot_reg   <= 1'b0;
            rev_ot_reg   <= 1'b0;
            irq_stat_reg <= 4'h0;
        end
        else
        begin
            state_reg    <= state_next;
            lockout_reg  <= lockout_next;
            en_prev_reg  <= en_lvl;
            fwd_ot_reg   <= fwd_ot;
            rev_ot_reg   <= rev_ot;
            irq_stat_reg <= irq_stat_next;
        end
    end

    // Registered drive outputs
    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            drive_o <= '0;
            stop_mode_o <= STOP_SVOFF;
            servo_off_stop_method_o <= 2'h0;
            overtravel_decel_rate_o <= `SEO_DECEL_RST;
            irq_o <= 1'b0;
        end
        else
        begin
            drive_o.power     <= power_next;
            drive_o.allow_fwd <= moving_ok & !fwd_ot;
            drive_o.allow_rev <= moving_ok & !rev_ot;
            drive_o.pos_done  <= power_next & motion_i.at_target & !ot_now
                                 & !motion_i.sw_limit;
            drive_o.fwd_ot    <= fwd_ot;
            drive_o.rev_ot    <= rev_ot;
            stop_mode_o <= stop_next;
            servo_off_stop_method_o <= cfg_act_reg.servo_off_stop_method;
            overtravel_decel_rate_o <= decel_reg;
            irq_o <= |(irq_stat_next & irq_mask_reg);
        end
    end

    // AXI4-Lite write channel
    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `SEO_RESP_OKAY;
            aw_addr_reg   <= 8'h00;
            w_data_reg    <= 32'h0;
            w_strb_reg    <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_addr_reg   <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_data_reg   <= s_axi_wdata;
                w_strb_reg   <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire)
            begin
                s_axi_bvalid  <= 1'b1;
                s_axi_bresp   <= wr_hit ? `SEO_RESP_OKAY : `SEO_RESP_SLVERR;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // AXI4-Lite read channel
    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= `SEO_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_val;
            s_axi_rresp   <= rd_hit ? `SEO_RESP_OKAY : `SEO_RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    a_enable_off_power: assert property (!en_lvl |=> !drive_o.power)
        else $error("power on while enable decoded off");
    a_enable_select_never: assert property (
        cfg_act_reg.servo_enable_input_select == `SEO_SEL_NEVER |=> !drive_o.power)
        else $error("power on with enable forced off");
    a_fwd_open_block: assert property (
        cfg_act_reg.forward_limit_select == 2'h0 && !sync2_reg[1]
        |=> drive_o.fwd_ot && !drive_o.allow_fwd)
        else $error("open forward contact did not block");
    a_rev_open_block: assert property (
        cfg_act_reg.reverse_limit_select == 2'h0 && !sync2_reg[2]
        |=> drive_o.rev_ot && !drive_o.allow_rev)
        else $error("open reverse contact did not block");
    a_opposite_allowed: assert property (
        state_reg == ST_LOCK && power_ok && fwd_ot && !rev_ot && !restart_now
        |=> drive_o.allow_rev)
        else $error("reverse blocked during forward overtravel");
    a_fwd_ignored: assert property (
        cfg_act_reg.forward_limit_select == `SEO_SEL_NEVER |=> !drive_o.fwd_ot)
        else $error("ignored forward limit flagged");
    a_rev_always: assert property (
        cfg_act_reg.reverse_limit_select == `SEO_SEL_ALWAYS |=> !drive_o.allow_rev)
        else $error("always-blocked reverse allowed");
    a_pos_not_done: assert property (
        ot_now || motion_i.sw_limit |=> !drive_o.pos_done)
        else $error("positioning done during limit");
    a_ot_svoff_stop: assert property (
        lock_set && !restart_now |=> stop_mode_o == STOP_SVOFF ##1 !drive_o.power)
        else $error("method 0 did not servo off");
    a_ot_immed_stop: assert property (
        state_reg == ST_RUN && power_ok && ot_onset && !restart_now
        && cfg_act_reg.overtravel_stop_method == 2'h1 |=> stop_mode_o == STOP_IMMED)
        else $error("method 1 did not stop at once");
    a_ot_decel_stop: assert property (
        state_reg == ST_RUN && power_ok && ot_onset && !restart_now
        && cfg_act_reg.overtravel_stop_method == 2'h2 |=> stop_mode_o == STOP_DECEL_RAMP)
        else $error("method 2 did not ramp");
    a_decel_in_range: assert property (
        decel_reg >= `SEO_DECEL_MIN && decel_reg <= `SEO_DECEL_MAX)
        else $error("decel rate out of range");
    a_lockout_holds: assert property (
        lockout_reg && !en_rise && !serial_servo_enable_command_accept && !restart_now |=> lockout_reg ##1 !drive_o.power)
        else $error("lockout released without event");
    a_serial_servo_enable_command_releases: assert property (
        lockout_reg && serial_servo_enable_command_accept && !lock_set |=> !lockout_reg)
        else $error("serial servo on ignored");
    a_always_on_lock: assert property (
        lockout_reg && !restart_now
        && cfg_act_reg.servo_enable_input_select == `SEO_SEL_ALWAYS |=> lockout_reg)
        else $error("always-on lockout released");

endmodule
`default_nettype wire

/* seo_contact_model.sv */
`timescale 1ns/1ns
`default_nettype none

module seo_contact_model
    import seo_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        en_closed_i,
    input  wire logic        fwd_closed_i,
    input  wire logic        rev_closed_i,
    input  wire logic        stopped_i,
    input  wire logic        sw_limit_i,
    output var  logic        servo_enable_o = 1'b0,
    output var  logic        forward_limit_o = 1'b1,
    output var  logic        reverse_limit_o = 1'b1,
    output var  seo_motion_t motion_o = 5'h18
);
    // Contacts move one cycle after the host decides; motor sits at target
    always @(posedge core_clk_i)
    begin
        servo_enable_o <= en_closed_i;
        forward_limit_o <= fwd_closed_i;
        reverse_limit_o <= rev_closed_i;
        motion_o <= {3'b111, sw_limit_i, stopped_i};
    end
endmodule

`default_nettype wire

/* seo_servo_enable_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "seo_params.svh"
`define CHK(g, e, m) chk((g) === (e), m)

module seo_servo_enable_tb
    import seo_pkg::*;
;
    logic        core_clk_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic        en_c = 1'b0, fwd_c = 1'b1, rev_c = 1'b1, stp = 1'b0, swl = 1'b0;
    logic        sen, fl, rl, irq, awr, wr_r, bv, arr, rv;
    seo_motion_t mot;
    seo_drive_t  drv;
    seo_stop_t   smode;
    logic [1:0]  sosm, bresp, rresp, resp;
    logic [26:0] decel;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd_v, act = 32'h0;
    logic        awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
    int          err_total = 0, checked = 0, cycles = 0;

    seo_contact_model seo_contact_model_inst (.core_clk_i(core_clk_i), .en_closed_i(en_c),
        .fwd_closed_i(fwd_c), .rev_closed_i(rev_c), .stopped_i(stp), .servo_enable_o(sen),
        .forward_limit_o(fl), .reverse_limit_o(rl), .motion_o(mot), .sw_limit_i(swl));
    seo_servo_enable seo_servo_enable_inst (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
        .servo_enable_i(sen), .forward_limit_input_i(fl), .reverse_limit_input_i(rl),
        .motion_i(mot), .drive_o(drv), .stop_mode_o(smode), .servo_off_stop_method_o(sosm),
        .overtravel_decel_rate_o(decel), .irq_o(irq), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr));

    initial
    begin
        forever #5 core_clk_i = ~core_clk_i;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge core_clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            err_total++;
            complete_run();
        end
    end

    task automatic w(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask

    task automatic chk(input bit ok, input string m);
        checked++;
        if (!ok)
        begin
            err_total++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        awaddr <= a;
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        do
        begin
            @(posedge core_clk_i);
            if (awr) awv <= 1'b0;
            if (wr_r) wv <= 1'b0;
        end while (!bv);
        resp = bresp;
        br <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge core_clk_i);
        araddr <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do
        begin
            @(posedge core_clk_i);
            if (arr) arv <= 1'b0;
        end while (!rv);
        rd_v = rdata;
        resp = rresp;
        rr <= 1'b0;
    endtask

    task automatic restart(input logic [31:0] c);
        wr(`SEO_ADDR_CFG, c);
        rd(`SEO_ADDR_CFG_ACT);
        `CHK(rd_v, act, "config still pending");
        act = c & 32'h3FF;
        wr(`SEO_ADDR_CMD, 32'h2);
        w(6);
        rd(`SEO_ADDR_CFG_ACT);
        `CHK(rd_v, act, "config active");
    endtask

    task automatic t_reset();
        `CHK(drv, 6'h00, "drive after reset");
        `CHK(irq, 1'b0, "irq after reset");
        rd(`SEO_ADDR_DECEL);
        `CHK(rd_v, 32'h3E8, "decel reset");
        rd(8'h40);
        `CHK(resp, `SEO_RESP_SLVERR, "unmapped read");
        wr(8'h40, 32'h1);
        `CHK(resp, `SEO_RESP_SLVERR, "unmapped write");
        $display("test reset done");
    endtask

    task automatic t_lockout();
        en_c <= 1'b1;
        w(6);
        `CHK(drv.power, 1'b1, "servo on");
        fwd_c <= 1'b0;
        w(6);
        `CHK(drv.fwd_ot, 1'b1, "fwd flag");
        `CHK(drv.allow_fwd, 1'b0, "fwd blocked");
        `CHK(drv.power, 1'b0, "ot servo off");
        `CHK(smode, STOP_SVOFF, "ot stop as servo off");
        fwd_c <= 1'b1;
        w(6);
        `CHK(drv.power, 1'b0, "lockout held");
        rd(`SEO_ADDR_STATUS);
        `CHK(rd_v, 32'h8, "lockout status");
        en_c <= 1'b0;
        w(6);
        en_c <= 1'b1;
        w(6);
        `CHK(drv.power, 1'b1, "toggle re-enable");
        rev_c <= 1'b0;
        w(6);
        `CHK(drv.rev_ot, 1'b1, "rev flag");
        `CHK(drv.allow_rev, 1'b0, "rev blocked");
        `CHK(drv.pos_done, 1'b0, "no pos done");
        rev_c <= 1'b1;
        w(6);
        wr(`SEO_ADDR_CMD, 32'h1);
        w(4);
        `CHK(drv.power, 1'b1, "serial re-enable");
        `CHK(drv.pos_done, 1'b1, "pos done");
        swl <= 1'b1;
        w(4);
        `CHK(drv.pos_done, 1'b0, "sw limit no pos done");
        swl <= 1'b0;
        $display("test lockout done");
    endtask

    task automatic t_select();
        logic [3:0] pw, fo, ro;
        pw = 4'b0110;
        fo = 4'b0110;
        ro = 4'b0101;
        en_c <= 1'b0;
        rev_c <= 1'b0;
        for (int s = 0; s < 4; s++)
        begin
            restart(32'h3C | s | (s << 8));
            `CHK(drv.power, pw[s], "enable select");
            `CHK(sosm, s[1:0], "servo off method");
            restart(32'h3 | (s << 2) | (s << 4));
            `CHK(drv.fwd_ot, fo[s], "fwd select");
            `CHK(drv.rev_ot, ro[s], "rev select");
        end
        rev_c <= 1'b1;
        restart(32'hC2);
        fwd_c <= 1'b0;
        w(6);
        fwd_c <= 1'b1;
        w(6);
        wr(`SEO_ADDR_CMD, 32'h1);
        w(4);
        `CHK(drv.power, 1'b0, "always on lockout");
        restart(32'h2);
        `CHK(drv.power, 1'b1, "power cycle");
        $display("test select done");
    endtask

    task automatic t_decel();
        wr(`SEO_ADDR_DECEL, 32'h5);
        w(2);
        `CHK(decel, 27'h5, "decel set");
        wr(`SEO_ADDR_DECEL, 32'h0);
        wr(`SEO_ADDR_DECEL, 32'h5F5E100);
        w(2);
        `CHK(decel, 27'h5, "decel range");
        wr(`SEO_ADDR_DECEL, 32'h5F5E0FF);
        w(2);
        `CHK(decel, 27'h5F5E0FF, "decel max");
        $display("test decel done");
    endtask

    task automatic t_stops();
        en_c <= 1'b1;
        wr(`SEO_ADDR_IRQ_MASK, 32'h8);
        restart(32'h40);
        fwd_c <= 1'b0;
        w(5);
        `CHK(smode, STOP_IMMED, "stop at once");
        w(1);
        `CHK(smode, STOP_HOLD, "stop then lock");
        `CHK(drv.power, 1'b1, "lock powered");
        `CHK(drv.allow_rev, 1'b1, "rev allowed");
        `CHK(irq, 1'b1, "lock irq");
        wr(`SEO_ADDR_IRQ_STAT, 32'hF);
        w(2);
        `CHK(irq, 1'b0, "irq cleared");
        rd(`SEO_ADDR_IRQ_STAT);
        `CHK(rd_v, 32'h0, "status cleared");
        fwd_c <= 1'b1;
        restart(32'h80);
        rev_c <= 1'b0;
        w(6);
        `CHK(smode, STOP_DECEL_RAMP, "ramp");
        stp <= 1'b1;
        w(4);
        `CHK(smode, STOP_HOLD, "ramp then lock");
        `CHK(drv.allow_fwd, 1'b1, "fwd allowed");
        `CHK(irq, 1'b1, "ramp irq");
        wr(`SEO_ADDR_IRQ_MASK, 32'h0);
        w(2);
        `CHK(irq, 1'b0, "irq masked");
        $display("test stops done");
    endtask

    initial
    begin
        w(8);
        nrst_i <= 1'b1;
        w(1);
        t_reset();
        t_lockout();
        t_select();
        t_decel();
        t_stops();
        complete_run();
    end
endmodule

`default_nettype wire
